// file: rtcc_pkg.sv
// Register map, field layout, reset values and sub-timer geometry of the
// real-time clock chain. Assumes a 32-bit APB with byte addresses.
package rtcc_pkg;

	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam int          WORD_W          = 16;

	// Register byte offsets
	localparam logic [11:0] OFS_CONTROL     = 12'h000;
	localparam logic [11:0] OFS_PRESCALER   = 12'h004;
	localparam logic [11:0] OFS_PRESC_RELOAD = 12'h008;
	localparam logic [11:0] OFS_COUNT_LOW   = 12'h00C;
	localparam logic [11:0] OFS_COUNT_HIGH  = 12'h010;
	localparam logic [11:0] OFS_RELOAD_LOW  = 12'h014;
	localparam logic [11:0] OFS_RELOAD_HIGH = 12'h018;
	localparam logic [11:0] OFS_IRQ_SUBNODE = 12'h01C;

	// Control register fields
	localparam int          CTRL_RUN_BIT    = 0;
	localparam int          CTRL_DOWN_BIT   = 2;
	localparam int          CTRL_UP_BIT     = 3;
	localparam logic        RUN_RESET       = 1'b1;

	// Reset value of the data registers and prescaler overflow value
	localparam logic [15:0] WORD_RESET      = 16'h0000;
	localparam logic [15:0] PRESC_MAX       = 16'hFFFF;

	// Values software is advised to use: ms, s, min, h, day
	localparam logic [15:0] TYP_PRESC_RELOAD = 16'hF448;
	localparam logic [15:0] TYP_RELOAD_LOW  = 16'h1018;
	localparam logic [15:0] TYP_RELOAD_HIGH = 16'hFA04;

	// Sub-timers inside the 32-bit time counter: sec, min, hour, day
	localparam int          NUM_SUB         = 4;
	localparam int          SUB_LSB [NUM_SUB] = '{0, 10, 16, 22};
	localparam int          SUB_W   [NUM_SUB] = '{10, 6, 6, 10};

	// Interrupt subnode layout
	localparam int          ISN_TICK_EN     = 0;
	localparam int          ISN_TICK_FLAG   = 1;
	localparam int          ISN_SUB_EN0     = 2;
	localparam int          ISN_SUB_FLAG0   = 3;
	localparam int          NUM_SRC         = NUM_SUB + 1;

endpackage : rtcc_pkg

// file: rtcc_edge_sync.sv
// Two-flop synchroniser for the asynchronous count clock, with a rising
// edge pulse taken from the synchronised copy. Runs on the system clock.
module rtcc_edge_sync
(
	// System
	input  wire logic pclk,
	input  wire logic presetn,
	// Asynchronous level
	input  wire logic async_in,
	// One-cycle pulse per rising edge
	output logic      rise_pulse
);

	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign rise_pulse = sync_reg & ~last_reg;

endmodule : rtcc_edge_sync

// file: rtcc_subtimer.sv
// One reloadable up-counting stage of the time counter. Software load
// has priority; an increment at all ones reloads and signals overflow.
module rtcc_subtimer
#(
	parameter int W = 10
)
(
	// System
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic         inc,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic [W-1:0] reload_val,
	// State
	output logic [W-1:0]      count,
	output logic              ovf
);

	logic [W-1:0] count_reg;

	assign ovf   = inc & ~load & (&count_reg);
	assign count = count_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= '0;
		else if (load)
			count_reg <= load_val;
		else if (ovf)
			count_reg <= reload_val;
		else if (inc)
			count_reg <= count_reg + W'(1);
	end

endmodule : rtcc_subtimer

// file: rtcc_chain.sv
// Real-time clock: reloadable 16-bit tick prescaler feeding four reloadable
// sub-timers, with an interrupt subnode. APB slave, zero wait states.
// Assumes a free-running count clock input, asynchronous to pclk.

// Function
// - Count clock is asynchronous; it is synchronised into the system clock.
// - A 16-bit reloadable prescaler drives a 32-bit time counter, two words.
// - Each prescaler overflow reloads it from the prescaler reload register.
// - A reload written during the overflow cycle passes straight through.
// - Counting only while run bit is set; reset sets the run bit.
// - Step-down or step-up bit adjusts prescaler once, then hardware clears it.
// - Only hardware reset clears registers; counting never stops for idle.
// - Every prescaler overflow raises the tick interrupt request.
// - Each sub-timer overflow raises its own interrupt request.
// - Each source has enable and flag; enabled flags ORed to one request.
// - Flags stay set until software clears them by writing one.
// - Combined request feeds one input of the shared interrupt subnode.
// - Reloads F448, 1018, FA04 give ms, s, min, hour, day overflows.
// - All reloads zero makes a 48-bit binary counter at count rate.
// - Low word: seconds 9..0, minutes 15..10; high: hours 5..0, days 15..6.
// - Control: run bit 0, step-down bit 2, step-up bit 3.
// - Subnode: tick enable 0, flag 1; sub-timer n enable 2+2n, flag 3+2n.
module rtcc_chain
(
	// System
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Count clock
	input  wire logic        count_clk_in,
	// Combined request to the shared interrupt subnode
	output logic             clock_irq
);

	// Address decode shared by the error answer and the write strobes
	function automatic logic rtcc_is_mapped(input logic [11:0] a);
		logic hit;
		hit = 1'b0;
		unique case (a)
			rtcc_pkg::OFS_CONTROL,
			rtcc_pkg::OFS_PRESCALER,
			rtcc_pkg::OFS_PRESC_RELOAD,
			rtcc_pkg::OFS_COUNT_LOW,
			rtcc_pkg::OFS_COUNT_HIGH,
			rtcc_pkg::OFS_RELOAD_LOW,
			rtcc_pkg::OFS_RELOAD_HIGH,
			rtcc_pkg::OFS_IRQ_SUBNODE:
				hit = 1'b1;
			default:
				hit = 1'b0;
		endcase
		return hit;
	endfunction : rtcc_is_mapped

	// Strobe of one register's write, qualified by a mapped access
	function automatic logic rtcc_wr_hit(input logic wr_valid,
		input logic [11:0] a, input logic [11:0] ofs);
		return wr_valid && a == ofs;
	endfunction : rtcc_wr_hit

	logic        count_edge;
	logic        count_tick;
	logic        acc;
	logic        wr;
	logic        wr_ok;
	logic [15:0] wdat;
	logic        wr_ctrl;
	logic        wr_presc;
	logic        wr_prel;
	logic        wr_cntl;
	logic        wr_cnth;
	logic        wr_rell;
	logic        wr_relh;
	logic        wr_isn;
	logic        run_reg;
	logic        step_down_reg;
	logic        step_up_reg;
	logic        step_up_go;
	logic        step_down_go;
	logic [15:0] presc_reg;
	logic [15:0] presc_reload_reg;
	logic [15:0] reload_src;
	logic        presc_ovf;
	logic [15:0] reload_low_reg;
	logic [15:0] reload_high_reg;
	logic [31:0] time_reload;
	logic [31:0] time_count;
	logic [31:0] wr_word32;
	logic [rtcc_pkg::NUM_SUB:0]   carry;
	logic [rtcc_pkg::NUM_SRC-1:0] irq_en_reg;
	logic [rtcc_pkg::NUM_SRC-1:0] irq_flag_reg;
	logic [rtcc_pkg::NUM_SRC-1:0] irq_event;
	logic [15:0] ctrl_word;
	logic [15:0] subnode_word;
	logic [15:0] rd_word;
	logic [31:0] prdata_reg;

	// Count clock crossing
	rtcc_edge_sync u_sync
	(
		.pclk       (pclk),
		.presetn    (presetn),
		.async_in   (count_clk_in),
		.rise_pulse (count_edge)
	);

	assign count_tick = count_edge & run_reg;

	// APB decode; byte strobes not honoured, registers are word-wide
	assign acc      = psel & penable;
	assign wr       = acc & pwrite;
	assign wr_ok    = wr & rtcc_is_mapped(paddr);
	assign wdat     = pwdata[15:0];
	assign wr_ctrl  = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_CONTROL);
	assign wr_presc = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_PRESCALER);
	assign wr_prel  = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_PRESC_RELOAD);
	assign wr_cntl  = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_COUNT_LOW);
	assign wr_cnth  = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_COUNT_HIGH);
	assign wr_rell  = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_RELOAD_LOW);
	assign wr_relh  = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_RELOAD_HIGH);
	assign wr_isn   = rtcc_wr_hit(wr_ok, paddr, rtcc_pkg::OFS_IRQ_SUBNODE);

	assign pready  = 1'b1;
	assign pslverr = acc & ~rtcc_is_mapped(paddr);

	// Control register; asynchronous reset only, no soft clear path
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_reg <= rtcc_pkg::RUN_RESET;
		else if (wr_ctrl)
			run_reg <= wdat[rtcc_pkg::CTRL_RUN_BIT];
	end

	// Steps wait for a cycle without a count tick, so none is lost
	assign step_up_go   = step_up_reg & ~count_tick & ~wr_presc;
	assign step_down_go = step_down_reg & ~step_up_reg & ~count_tick
		& ~wr_presc;

	// A step written while one is pending merges into it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_up_reg <= 1'b0;
		else
			step_up_reg <= (wr_ctrl & wdat[rtcc_pkg::CTRL_UP_BIT])
				| (step_up_reg & ~step_up_go);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_down_reg <= 1'b0;
		else
			step_down_reg <= (wr_ctrl & wdat[rtcc_pkg::CTRL_DOWN_BIT])
				| (step_down_reg & ~step_down_go);
	end

	// Tick prescaler
	assign presc_ovf = (count_tick | step_up_go) & ~wr_presc
		& (presc_reg == rtcc_pkg::PRESC_MAX);
	assign reload_src = wr_prel ? wdat : presc_reload_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc_reg <= rtcc_pkg::WORD_RESET;
		else if (wr_presc)
			presc_reg <= wdat;
		else if (presc_ovf)
			presc_reg <= reload_src;
		else if (count_tick | step_up_go)
			presc_reg <= presc_reg + 16'h0001;
		else if (step_down_go)
			presc_reg <= presc_reg - 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc_reload_reg <= rtcc_pkg::WORD_RESET;
		else if (wr_prel)
			presc_reload_reg <= wdat;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reload_low_reg <= rtcc_pkg::WORD_RESET;
		else if (wr_rell)
			reload_low_reg <= wdat;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reload_high_reg <= rtcc_pkg::WORD_RESET;
		else if (wr_relh)
			reload_high_reg <= wdat;
	end

	// Sub-timers take their reload fields from this joined word
	assign time_reload = {reload_high_reg, reload_low_reg};

	// Time counter: carry ripples from prescaler through four stages
	assign carry[0]  = presc_ovf;
	assign wr_word32 = wr_cntl ? {16'h0000, wdat} : {wdat, 16'h0000};

	generate
		for (genvar i = 0; i < rtcc_pkg::NUM_SUB; i++)
		begin : g_sub
			localparam int LSB = rtcc_pkg::SUB_LSB[i];
			localparam int W   = rtcc_pkg::SUB_W[i];
			logic load;
			assign load = (i < 2) ? wr_cntl : wr_cnth;
			rtcc_subtimer #(.W(W)) u_sub
			(
				.pclk       (pclk),
				.presetn    (presetn),
				.inc        (carry[i]),
				.load       (load),
				.load_val   (wr_word32[LSB +: W]),
				.reload_val (time_reload[LSB +: W]),
				.count      (time_count[LSB +: W]),
				.ovf        (carry[i+1])
			);
		end
	endgenerate

	// Interrupt subnode
	assign irq_event = {carry[rtcc_pkg::NUM_SUB:1], presc_ovf};

	generate
		for (genvar s = 0; s < rtcc_pkg::NUM_SRC; s++)
		begin : g_irq
			// Source 0 is the tick, then sub-timers from seconds upward
			localparam int EN_POS   = rtcc_pkg::ISN_TICK_EN + 2 * s;
			localparam int FLAG_POS = rtcc_pkg::ISN_TICK_FLAG + 2 * s;
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					irq_en_reg[s]   <= 1'b0;
					irq_flag_reg[s] <= 1'b0;
				end
				else
				begin
					if (wr_isn)
						irq_en_reg[s] <= wdat[EN_POS];
					// Set wins over a clear in the same cycle
					irq_flag_reg[s] <= irq_event[s] | (irq_flag_reg[s]
						& ~(wr_isn & wdat[FLAG_POS]));
				end
			end
			assign subnode_word[EN_POS]   = irq_en_reg[s];
			assign subnode_word[FLAG_POS] = irq_flag_reg[s];
		end
	endgenerate

	assign subnode_word[15:2*rtcc_pkg::NUM_SRC] = '0;
	assign clock_irq = |(irq_en_reg & irq_flag_reg);

	// Control read-back; pending step bits show until they are applied
	always_comb
	begin
		ctrl_word                          = 16'h0000;
		ctrl_word[rtcc_pkg::CTRL_RUN_BIT]  = run_reg;
		ctrl_word[rtcc_pkg::CTRL_DOWN_BIT] = step_down_reg;
		ctrl_word[rtcc_pkg::CTRL_UP_BIT]   = step_up_reg;
	end

	// Read mux; data captured in setup phase so it is stable in access
	always_comb
	begin
		unique case (paddr)
			rtcc_pkg::OFS_CONTROL:      rd_word = ctrl_word;
			rtcc_pkg::OFS_PRESCALER:    rd_word = presc_reg;
			rtcc_pkg::OFS_PRESC_RELOAD: rd_word = presc_reload_reg;
			rtcc_pkg::OFS_COUNT_LOW:    rd_word = time_count[15:0];
			rtcc_pkg::OFS_COUNT_HIGH:   rd_word = time_count[31:16];
			rtcc_pkg::OFS_RELOAD_LOW:   rd_word = reload_low_reg;
			rtcc_pkg::OFS_RELOAD_HIGH:  rd_word = reload_high_reg;
			rtcc_pkg::OFS_IRQ_SUBNODE:  rd_word = subnode_word;
			default:                    rd_word = 16'h0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (psel & ~penable)
			prdata_reg <= {16'h0000, rd_word};
	end

	assign prdata = prdata_reg;

endmodule : rtcc_chain

// file: rtcc_chain_checker.sv
// Port checker for the clock chain: APB answers and the combined request.
// Assumes the rtcc_chain ports and byte offsets of rtcc_pkg.
module rtcc_chain_checker
(
	// System
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt
	input wire logic        clock_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic acc = psel && penable;
	wire logic hit = paddr <= rtcc_pkg::OFS_IRQ_SUBNODE && paddr[1:0] == 2'h0;
	wire logic isn_wr = acc && pwrite && paddr == rtcc_pkg::OFS_IRQ_SUBNODE;
	sequence s_rd;
		acc && !pwrite;
	endsequence
	sequence s_mask_off;
		isn_wr && (pwdata[9:0] & 10'h155) == 10'h000;
	endsequence
	bad_addr_err_a: assert property (acc && !hit |-> pslverr)
		else $error("no error on unmapped access");
	good_addr_ok_a: assert property (acc && hit |-> !pslverr)
		else $error("error on mapped access");
	bad_read_zero_a: assert property (s_rd ##0 !hit |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	upper_half_zero_a: assert property (prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	ctl_spare_bits_a: assert property (s_rd ##0 paddr == 12'h000 |->
		prdata[15:4] == 12'h000 && !prdata[1])
		else $error("control spare bits set");
	isn_spare_bits_a: assert property (s_rd ##0 paddr == 12'h01C |->
		prdata[15:10] == 6'h00)
		else $error("subnode spare bits set");
	flag_sticky_a: assert property ($fell(clock_irq) |-> $past(isn_wr))
		else $error("request dropped without software write");
	mask_off_quiet_a: assert property (s_mask_off |=> !clock_irq)
		else $error("request with all sources disabled");
	read_holds_a: assert property (s_rd |=> $stable(prdata))
		else $error("read data moved after access");
endmodule : rtcc_chain_checker

bind rtcc_chain rtcc_chain_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.clock_irq(clock_irq));

// file: rtcc_count_src.sv
// Count clock source at 3 MHz, asynchronous to the system clock.
// Assumes one go pulse per wanted rising edge; idle low in between.
module rtcc_count_src
(
	// Request
	input wire logic go,
	// Count clock
	output logic     count_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial count_clk = 1'b0;
	// Odd offset keeps edges away from the pclk grid
	always @(posedge go)
	begin
		#41.3;
		count_clk = 1'b1;
		#166.667;
		count_clk = 1'b0;
	end
endmodule : rtcc_count_src

// file: rtcc_chain_tb.sv
// Self-checking bench for the clock chain, driven over APB.
// Assumes the count source model feeds the count input.
module rtcc_chain_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, go, cclk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, clock_irq;
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	rtcc_chain u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_clk_in(cclk), .clock_irq(clock_irq));
	rtcc_count_src u_src (.go(go), .count_clk(cclk));
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [15:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a hung wait
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following call never re-drives psel this step
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 16'h0000, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rc
	task automatic tick();
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (80) @(posedge pclk);
	endtask : tick
	task automatic t_reset();
		for (int i = 0; i < 8; i++)
			rc(12'(4 * i), {31'h0, i == 0}, 1'b0);
		rc(12'h020, 32'h0, 1'b1);
		wr(12'h0FC, 16'hFFFF);
		rc(12'h0FC, 32'h0, 1'b1);
		$display("test reset and unmapped done");
	endtask : t_reset
	// Prescaler starts at all ones; counts of all ones let one tick ripple the whole chain
	task automatic t_chain(input logic [15:0] pr, rl, rh, cl, ch,
		ep, el, eh, ei);
		wr(12'h008, pr);
		wr(12'h014, rl);
		wr(12'h018, rh);
		wr(12'h004, 16'hFFFF);
		wr(12'h00C, cl);
		wr(12'h010, ch);
		wr(12'h01C, 16'h03FF);
		tick();
		rc(12'h004, {16'h0, ep}, 1'b0);
		rc(12'h00C, {16'h0, el}, 1'b0);
		rc(12'h010, {16'h0, eh}, 1'b0);
		rc(12'h01C, {16'h0, ei}, 1'b0);
		chk({31'h0, clock_irq}, 32'h1);
		wr(12'h01C, 16'h0157);
		rc(12'h01C, {16'h0, ei & 16'hFFFD}, 1'b0);
		wr(12'h01C, 16'h02A8);
		rc(12'h01C, 32'h0, 1'b0);
		chk({31'h0, clock_irq}, 32'h0);
		$display("test chain overflow done");
	endtask : t_chain
	task automatic t_run_step();
		wr(12'h000, 16'h0000);
		tick();
		rc(12'h004, 32'h0, 1'b0);
		wr(12'h000, 16'h0001);
		tick();
		rc(12'h004, 32'h1, 1'b0);
		wr(12'h000, 16'h0009);
		repeat (2) @(posedge pclk);
		rc(12'h004, 32'h2, 1'b0);
		rc(12'h000, 32'h1, 1'b0);
		wr(12'h000, 16'h0005);
		repeat (2) @(posedge pclk);
		rc(12'h004, 32'h1, 1'b0);
		$display("test run and step done");
	endtask : t_run_step
	task automatic t_hw_reset();
		wr(12'h008, 16'h1234);
		wr(12'h000, 16'h0000);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc(12'h000, 32'h1, 1'b0);
		rc(12'h008, 32'h0, 1'b0);
		rc(12'h004, 32'h0, 1'b0);
		tick();
		rc(12'h004, 32'h1, 1'b0);
		$display("test mid-run reset done");
	endtask : t_hw_reset
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		go = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_chain(16'hF448, 16'h1018, 16'hFA04, 16'hFFFF, 16'hFFFF,
			16'hF448, 16'h1018, 16'hFA04, 16'h03FF);
		t_chain(16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
			16'h0, 16'h0001, 16'h0, 16'h0157);
		t_run_step();
		t_hw_reset();
		report_and_stop();
	end
endmodule : rtcc_chain_tb
